// [core/xsd_cond_eval.sv]
`timescale 1ns/100ps
`default_nettype none

module xsd_cond_eval
(
  // Decoded operation
  input  wire logic [3:0]  op,
  // Flag word
  input  wire logic [15:0] flags,
  // Result
  output logic             holds
);

  logic cf;
  logic zf;
  logic sf;
  logic of_bit;

  assign cf     = flags[xsd_pkg::FLAG_CF];
  assign zf     = flags[xsd_pkg::FLAG_ZF];
  assign sf     = flags[xsd_pkg::FLAG_SF];
  assign of_bit = flags[xsd_pkg::FLAG_OF];

  always_comb
  begin
    case (xsd_pkg::xsd_op_t'(op))
      xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW:          holds = cf;
      xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL: holds = cf | zf;
      xsd_pkg::XSD_OP_SET_BYTE_IF_EQUAL:          holds = zf;
      xsd_pkg::XSD_OP_SET_BYTE_IF_LESS:           holds = sf ^ of_bit;
      xsd_pkg::XSD_OP_SET_BYTE_IF_LESS_OR_EQUAL:  holds = (sf ^ of_bit) | zf;
      default:                                    holds = 1'b0;
    endcase
  end

endmodule : xsd_cond_eval

`default_nettype wire

// [core/xsd_decode.sv]
`timescale 1ns/100ps
`default_nettype none

module xsd_decode
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Instruction stream
  input  wire logic        ins_valid,
  input  wire logic [7:0]  ins_op0,
  input  wire logic [7:0]  ins_op1,
  input  wire logic [7:0]  ins_modrm,
  input  wire logic [7:0]  ins_modrm2,
  input  wire logic        cache_hit,
  input  wire logic [15:0] flags_in,
  // Decode result
  output logic             dec_valid,
  output logic [3:0]       dec_op,
  output logic [1:0]       dec_src,
  output logic             dec_width,
  output logic             dec_dir,
  output logic             dec_sext,
  output logic             dec_imm_byte,
  output logic             dec_mem,
  output logic [1:0]       dec_clocks,
  // Set-byte result
  output logic             set_we,
  output logic [7:0]       set_data,
  output logic             flags_we,
  // Sequencing
  output logic             busy
);

  // ----------------------------------------------------------------
  // Field helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_field(input logic [7:0] m);
    reg_field = m[5:3];
  endfunction : reg_field

  function automatic logic is_mem(input logic [7:0] m);
    is_mem = (m[7:6] != xsd_pkg::MOD_REG_DIRECT);
  endfunction : is_mem

  // ----------------------------------------------------------------
  // One-byte opcode decode
  // ----------------------------------------------------------------
  logic [2:0] rf1;
  logic [2:0] rf2;
  logic       shift_by_one;
  logic       shift_by_cnt;
  logic       shift_by_imm;
  logic       shift_any;
  logic       sal_hit;
  logic       sar_hit;
  logic       sbb_rr;
  logic       sbb_to_mem;
  logic       sbb_to_reg;
  logic       sbb_imm;
  logic       esc;
  logic       set_b;
  logic       set_be;
  logic       set_e;
  logic       set_l;
  logic       set_le;
  logic       set_any;

  assign rf1 = reg_field(ins_op1);
  assign rf2 = reg_field(ins_modrm2);

  assign shift_by_one = (ins_op0[7:4] == xsd_pkg::OP_HI_SHIFT_BY_ONE_CNT)
                      & (ins_op0[3:1] == xsd_pkg::OP_LO_SHIFT_BY_ONE);
  assign shift_by_cnt = (ins_op0[7:4] == xsd_pkg::OP_HI_SHIFT_BY_ONE_CNT)
                      & (ins_op0[3:1] == xsd_pkg::OP_LO_SHIFT_BY_CNT);
  assign shift_by_imm = (ins_op0[7:4] == xsd_pkg::OP_HI_SHIFT_BY_IMM)
                      & (ins_op0[3:1] == xsd_pkg::OP_LO_SHIFT_BY_IMM);
  assign shift_any    = shift_by_one | shift_by_cnt | shift_by_imm;

  assign sal_hit = shift_any & (rf1 == xsd_pkg::REG_SHIFT_LEFT_ARITH);
  assign sar_hit = shift_any & (rf1 == xsd_pkg::REG_SHIFT_RIGHT_ARITH);

  assign sbb_rr     = (ins_op0[7:2] == xsd_pkg::OP_SBB_RR_TOP)
                    & (ins_op1[7:6] == xsd_pkg::MOD_REG_DIRECT);
  assign sbb_to_mem = (ins_op0[7:1] == xsd_pkg::OP_SBB_TO_MEM) & is_mem(ins_op1);
  assign sbb_to_reg = (ins_op0[7:1] == xsd_pkg::OP_SBB_TO_REG) & is_mem(ins_op1);
  assign sbb_imm    = (ins_op0[7:2] == xsd_pkg::OP_IMM_GROUP_TOP)
                    & (rf1 == xsd_pkg::REG_SBB_IMM);

  // ----------------------------------------------------------------
  // Two-byte set-byte decode
  // ----------------------------------------------------------------
  assign esc = (ins_op0 == xsd_pkg::OP_TWO_BYTE_ESC) & (rf2 == xsd_pkg::REG_SET_BYTE);
  assign set_b  = esc & (ins_op1 == xsd_pkg::OP2_SET_BELOW);
  assign set_be = esc & (ins_op1 == xsd_pkg::OP2_SET_BELOW_EQ);
  assign set_e  = esc & (ins_op1 == xsd_pkg::OP2_SET_EQUAL);
  assign set_l  = esc & (ins_op1 == xsd_pkg::OP2_SET_LESS);
  assign set_le = esc & (ins_op1 == xsd_pkg::OP2_SET_LESS_EQ);
  assign set_any = set_b | set_be | set_e | set_l | set_le;

  // ----------------------------------------------------------------
  // Selection of op, source and clock count
  // ----------------------------------------------------------------
  xsd_pkg::xsd_op_t  op_d;
  xsd_pkg::xsd_src_t src_d;
  logic [1:0]        clk_d;
  logic              sbb_any;

  assign sbb_any = sbb_rr | sbb_to_mem | sbb_to_reg | sbb_imm;

  always_comb
  begin
    op_d  = xsd_pkg::XSD_OP_NONE;
    clk_d = 2'h0;
    if (sal_hit)
    begin
      op_d = xsd_pkg::XSD_OP_ARITH_SHIFT_LEFT;
      clk_d = shift_by_imm ? xsd_pkg::CLK_SAL_IMM : xsd_pkg::CLK_SAL_CNT;
    end
    else if (sar_hit)
    begin
      op_d = xsd_pkg::XSD_OP_ARITH_SHIFT_RIGHT;
      clk_d = xsd_pkg::CLK_SHIFT_RIGHT;
    end
    else if (sbb_any)
    begin
      op_d = xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW;
      clk_d = xsd_pkg::CLK_SBB;
    end
    else if (set_any)
    begin
      clk_d = xsd_pkg::CLK_SET_BYTE;
      if (set_b)
        op_d = xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW;
      else if (set_be)
        op_d = xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL;
      else if (set_e)
        op_d = xsd_pkg::XSD_OP_SET_BYTE_IF_EQUAL;
      else if (set_l)
        op_d = xsd_pkg::XSD_OP_SET_BYTE_IF_LESS;
      else
        op_d = xsd_pkg::XSD_OP_SET_BYTE_IF_LESS_OR_EQUAL;
    end
  end

  always_comb
  begin
    if (shift_by_cnt)
      src_d = xsd_pkg::XSD_SRC_COUNT_REGISTER_LOW;
    else if (shift_by_imm | sbb_imm)
      src_d = xsd_pkg::XSD_SRC_IMMEDIATE;
    else if (shift_by_one & (sal_hit | sar_hit))
      src_d = xsd_pkg::XSD_SRC_ONE;
    else
      src_d = xsd_pkg::XSD_SRC_MODRM;
  end

  // ----------------------------------------------------------------
  // Set-byte condition
  // ----------------------------------------------------------------
  logic       cond_holds;
  logic [7:0] set_data_d;

  xsd_cond_eval u_xsd_cond_eval
  (
    .op    (op_d),
    .flags (flags_in),
    .holds (cond_holds)
  );

  assign set_data_d = cond_holds ? xsd_pkg::SET_BYTE_TRUE : xsd_pkg::SET_BYTE_FALSE;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XSD_ST_IDLE,
    XSD_ST_EXEC,
    XSD_ST_WAIT_CACHE
  } xsd_state_t;

  xsd_state_t state_q;
  xsd_state_t state_d;
  logic [1:0] left_q;
  logic [1:0] left_d;
  logic       known;
  logic       take;
  logic       mem_d;
  logic       need_hit;

  assign known    = (op_d != xsd_pkg::XSD_OP_NONE);
  assign take     = ins_valid & (state_q == XSD_ST_IDLE) & known;
  assign mem_d    = (sbb_any | sal_hit | sar_hit | set_any)
                  & is_mem(esc ? ins_modrm2 : ins_op1);
  // Only the memory-operand borrow subtract forms to memory and to register, not the immediate form, must hit the cache
  assign need_hit = sbb_to_mem | sbb_to_reg;

  always_comb
  begin
    state_d = state_q;
    left_d  = left_q;
    case (state_q)
      XSD_ST_IDLE:
      begin
        if (take)
        begin
          if (need_hit & ~cache_hit)
            state_d = XSD_ST_WAIT_CACHE;
          else if (clk_d > 2'h1)
          begin
            state_d = XSD_ST_EXEC;
            left_d  = clk_d - 2'h1;
          end
        end
      end
      XSD_ST_EXEC:
      begin
        left_d = left_q - 2'h1;
        if (left_q == 2'h1)
          state_d = XSD_ST_IDLE;
      end
      XSD_ST_WAIT_CACHE:
      begin
        // Miss penalty is the memory side's; we only hold off new work
        if (cache_hit)
          state_d = XSD_ST_IDLE;
      end
      default:
        state_d = XSD_ST_IDLE;
    endcase
  end

  logic busy_d;
  assign busy_d = (state_d != XSD_ST_IDLE);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= XSD_ST_IDLE;
      left_q  <= 2'h0;
      busy    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      left_q  <= left_d;
      busy    <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dec_valid    <= 1'b0;
      dec_op       <= 4'h0;
      dec_src      <= 2'h0;
      dec_width    <= 1'b0;
      dec_dir      <= 1'b0;
      dec_sext     <= 1'b0;
      dec_imm_byte <= 1'b0;
      dec_mem      <= 1'b0;
      dec_clocks   <= 2'h0;
      set_we       <= 1'b0;
      set_data     <= 8'h00;
      flags_we     <= 1'b0;
    end
    else
    begin
      dec_valid <= take;
      set_we    <= take & set_any;
      flags_we  <= take & ~set_any;
      if (take)
      begin
        dec_op       <= op_d;
        dec_src      <= src_d;
        dec_width    <= ~set_any & ins_op0[0];
        dec_dir      <= sbb_any & ~sbb_imm & ins_op0[1];
        dec_sext     <= sbb_imm & ins_op0[1];
        dec_imm_byte <= shift_by_imm | (sbb_imm & (ins_op0[1] | ~ins_op0[0]));
        dec_mem      <= mem_d;
        dec_clocks   <= clk_d;
        set_data     <= set_data_d;
      end
    end
  end

endmodule : xsd_decode

`default_nettype wire

// [core/xsd_pkg.sv]
`default_nettype none

package xsd_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_HI_SHIFT_BY_ONE_CNT = 4'hd;
  localparam logic [3:0] OP_HI_SHIFT_BY_IMM     = 4'hc;
  localparam logic [2:0] OP_LO_SHIFT_BY_ONE     = 3'h0;
  localparam logic [2:0] OP_LO_SHIFT_BY_CNT     = 3'h1;
  localparam logic [2:0] OP_LO_SHIFT_BY_IMM     = 3'h0;
  localparam logic [5:0] OP_SBB_RR_TOP          = 6'h06;
  localparam logic [6:0] OP_SBB_TO_MEM          = 7'h0c;
  localparam logic [6:0] OP_SBB_TO_REG          = 7'h0d;
  localparam logic [5:0] OP_IMM_GROUP_TOP       = 6'h20;
  localparam logic [7:0] OP_TWO_BYTE_ESC        = 8'h0f;
  localparam logic [7:0] OP2_SET_BELOW          = 8'h92;
  localparam logic [7:0] OP2_SET_BELOW_EQ       = 8'h96;
  localparam logic [7:0] OP2_SET_EQUAL          = 8'h94;
  localparam logic [7:0] OP2_SET_LESS           = 8'h9c;
  localparam logic [7:0] OP2_SET_LESS_EQ        = 8'h9e;

  // ----------------------------------------------------------------
  // Register-select field values and mod field
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_SHIFT_LEFT_ARITH   = 3'h4;
  localparam logic [2:0] REG_SHIFT_RIGHT_ARITH  = 3'h7;
  localparam logic [2:0] REG_SBB_IMM            = 3'h3;
  localparam logic [2:0] REG_SET_BYTE           = 3'h0;
  localparam logic [1:0] MOD_REG_DIRECT         = 2'h3;

  // ----------------------------------------------------------------
  // Clock counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_SAL_CNT            = 2'h2;
  localparam logic [1:0] CLK_SAL_IMM            = 2'h1;
  localparam logic [1:0] CLK_SHIFT_RIGHT        = 2'h2;
  localparam logic [1:0] CLK_SBB                = 2'h1;
  localparam logic [1:0] CLK_SET_BYTE           = 2'h1;

  // ----------------------------------------------------------------
  // Results and flag bits
  // ----------------------------------------------------------------
  localparam logic [7:0] SET_BYTE_TRUE          = 8'h01;
  localparam logic [7:0] SET_BYTE_FALSE         = 8'h00;
  localparam int         FLAG_CF                = 0;
  localparam int         FLAG_ZF                = 6;
  localparam int         FLAG_SF                = 7;
  localparam int         FLAG_OF                = 11;

  typedef enum logic [3:0] {
    XSD_OP_NONE,
    XSD_OP_ARITH_SHIFT_LEFT,
    XSD_OP_ARITH_SHIFT_RIGHT,
    XSD_OP_SUBTRACT_WITH_BORROW,
    XSD_OP_SET_BYTE_IF_BELOW,
    XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL,
    XSD_OP_SET_BYTE_IF_EQUAL,
    XSD_OP_SET_BYTE_IF_LESS,
    XSD_OP_SET_BYTE_IF_LESS_OR_EQUAL
  } xsd_op_t;

  typedef enum logic [1:0] {
    XSD_SRC_ONE,
    XSD_SRC_COUNT_REGISTER_LOW,
    XSD_SRC_IMMEDIATE,
    XSD_SRC_MODRM
  } xsd_src_t;

endpackage : xsd_pkg

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, rst, ins_valid, cache_hit;
  logic [7:0]  ins_op0, ins_op1, ins_modrm, ins_modrm2, set_data;
  logic [15:0] flags_in;
  logic [3:0]  dec_op;
  logic [1:0]  dec_src, dec_clocks;
  logic        dec_valid, dec_width, dec_dir, dec_sext, dec_imm_byte, dec_mem;
  logic        set_we, flags_we, busy;
  int          failures, checked, cycles;

  xsd_decode u_xsd_decode
  (
    .mclk(mclk), .rst(rst), .ins_valid(ins_valid), .ins_op0(ins_op0), .ins_op1(ins_op1),
    .ins_modrm(ins_modrm), .ins_modrm2(ins_modrm2), .cache_hit(cache_hit),
    .flags_in(flags_in), .dec_valid(dec_valid), .dec_op(dec_op), .dec_src(dec_src),
    .dec_width(dec_width), .dec_dir(dec_dir), .dec_sext(dec_sext),
    .dec_imm_byte(dec_imm_byte), .dec_mem(dec_mem), .dec_clocks(dec_clocks),
    .set_we(set_we), .set_data(set_data), .flags_we(flags_we), .busy(busy)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic put(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    ins_valid  <= 1'b1;
    ins_op0    <= b0;
    ins_op1    <= b1;
    ins_modrm2 <= b2;
  endtask : put

  // One offer, taken at the next edge; returns where outputs have settled
  task automatic offer(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge mclk);
    put(b0, b1, b2);
    @(posedge mclk);
    ins_valid <= 1'b0;
    @(negedge mclk);
  endtask : offer

  task automatic final_report;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // shift-left forms
  task automatic t_shift_left;
    offer(8'hd3, 8'he0, 8'h00);
    chk({dec_valid, dec_op, dec_src, dec_clocks, busy, flags_we},
        {1'b1, xsd_pkg::XSD_OP_ARITH_SHIFT_LEFT, xsd_pkg::XSD_SRC_COUNT_REGISTER_LOW,
         2'h2, 1'b1, 1'b1});
    @(negedge mclk);
    chk({dec_valid, busy}, 2'b00);
    offer(8'hc1, 8'he0, 8'h00);
    chk({dec_valid, dec_op, dec_src, dec_imm_byte, dec_clocks, busy, dec_width},
        {1'b1, xsd_pkg::XSD_OP_ARITH_SHIFT_LEFT, xsd_pkg::XSD_SRC_IMMEDIATE,
         1'b1, 2'h1, 1'b0, 1'b1});
  endtask : t_shift_left

  task automatic t_shift_right;
    logic [7:0] ops [3] = '{8'hd1, 8'hd3, 8'hc1};
    logic [1:0] srcs [3] = '{xsd_pkg::XSD_SRC_ONE, xsd_pkg::XSD_SRC_COUNT_REGISTER_LOW,
                             xsd_pkg::XSD_SRC_IMMEDIATE};
    for (int i = 0; i < 3; i++)
    begin
      offer(ops[i], 8'hf8, 8'h00);
      chk({dec_valid, dec_op, dec_src, dec_clocks, busy},
          {1'b1, xsd_pkg::XSD_OP_ARITH_SHIFT_RIGHT, srcs[i], 2'h2, 1'b1});
    end
  endtask : t_shift_right

  // borrow subtract, back to back and cache miss
  task automatic t_sbb;
    @(posedge mclk);
    put(8'h1b, 8'hc8, 8'h00);
    @(posedge mclk);
    put(8'h83, 8'hd8, 8'h00);
    @(negedge mclk);
    chk({dec_valid, dec_op, dec_src, dec_dir, dec_width, dec_mem, dec_clocks, flags_we},
        {1'b1, xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW, xsd_pkg::XSD_SRC_MODRM, 1'b1, 1'b1,
         1'b0, 2'h1, 1'b1});
    @(posedge mclk);
    ins_valid <= 1'b0;
    @(negedge mclk);
    chk({dec_valid, dec_op, dec_src, dec_sext, dec_width, dec_imm_byte, dec_clocks},
        {1'b1, xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW, xsd_pkg::XSD_SRC_IMMEDIATE, 1'b1, 1'b1,
         1'b1, 2'h1});
    offer(8'h1a, 8'h05, 8'h00);
    chk({dec_valid, dec_mem, dec_dir, dec_clocks, busy},
        {1'b1, 1'b1, 1'b1, 2'h1, 1'b0});
    offer(8'h19, 8'h45, 8'h00);
    chk({dec_valid, dec_mem, dec_dir}, {1'b1, 1'b1, 1'b0});
    // A miss must stall rather than complete in the cached time
    @(posedge mclk);
    cache_hit <= 1'b0;
    offer(8'h1a, 8'h05, 8'h00);
    repeat (3) @(negedge mclk);
    chk(busy, 1'b1);
    @(posedge mclk);
    cache_hit <= 1'b1;
    for (int i = 0; i < 4 && busy !== 1'b0; i++)
      @(negedge mclk);
    chk({busy, dec_op, dec_mem}, {1'b0, xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW, 1'b1});
  endtask : t_sbb

  task automatic t_set_byte;
    logic [7:0]  op2 [5] = '{8'h92, 8'h96, 8'h94, 8'h9c, 8'h9e};
    logic [3:0]  code [5] = '{xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW,
                              xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL,
                              xsd_pkg::XSD_OP_SET_BYTE_IF_EQUAL, xsd_pkg::XSD_OP_SET_BYTE_IF_LESS,
                              xsd_pkg::XSD_OP_SET_BYTE_IF_LESS_OR_EQUAL};
    // Flag words: none, carry, zero, sign, sign with overflow
    logic [15:0] pat [5] = '{16'h0000, 16'h0001, 16'h0040, 16'h0080, 16'h0880};
    logic [4:0]  tt [5] = '{5'b00010, 5'b00110, 5'b00100, 5'b01000, 5'b01100};
    for (int o = 0; o < 5; o++)
      for (int p = 0; p < 5; p++)
      begin
        @(posedge mclk);
        flags_in <= pat[p];
        offer(8'h0f, op2[o], 8'hc0);
        chk({set_we, dec_op}, {1'b1, code[o]});
        chk({flags_we, set_data}, {1'b0, 7'h00, tt[o][p]});
      end
  endtask : t_set_byte

  task automatic t_unknown;
    offer(8'h90, 8'h00, 8'h00);
    chk({dec_valid, set_we}, 2'b00);
    offer(8'h0f, 8'h93, 8'hc0);
    chk({dec_valid, set_we}, 2'b00);
  endtask : t_unknown

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    ins_valid = 1'b0;
    ins_op0 = 8'h00;
    ins_op1 = 8'h00;
    ins_modrm = 8'h00;
    ins_modrm2 = 8'h00;
    cache_hit = 1'b1;
    flags_in = 16'h0000;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_shift_left;
    t_shift_right;
    t_sbb;
    t_set_byte;
    t_unknown;
    final_report;
  end

  // Whole run needs well under 200 cycles; generous ceiling
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge mclk);
      cycles++;
      if (cycles == 3000)
      begin
        failures++;
        final_report;
      end
    end
  end
endmodule : tb_top

`default_nettype wire

// [verif/xsd_decode_props.sv]
`timescale 1ns/100ps
`default_nettype none

module xsd_decode_props
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Instruction stream
  input wire logic        ins_valid,
  input wire logic [7:0]  ins_op0,
  input wire logic [7:0]  ins_op1,
  input wire logic [7:0]  ins_modrm2,
  input wire logic        cache_hit,
  input wire logic [15:0] flags_in,
  // Decode result
  input wire logic        dec_valid,
  input wire logic [3:0]  dec_op,
  input wire logic [1:0]  dec_src,
  input wire logic        dec_width,
  input wire logic        dec_dir,
  input wire logic        dec_sext,
  input wire logic        dec_imm_byte,
  input wire logic        dec_mem,
  input wire logic [1:0]  dec_clocks,
  input wire logic        set_we,
  input wire logic [7:0]  set_data,
  input wire logic        flags_we,
  input wire logic        busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Offer decoding
  // ----------------------------------------------------------------
  wire logic       take;
  wire logic [2:0] reg1;
  wire logic       cf;
  wire logic       zf;
  wire logic       lt;
  wire logic       set_hold;
  xsd_pkg::xsd_op_t set_code;

  assign take = ins_valid && !busy;
  assign reg1 = ins_op1[5:3];
  assign cf   = flags_in[xsd_pkg::FLAG_CF];
  assign zf   = flags_in[xsd_pkg::FLAG_ZF];
  assign lt   = flags_in[xsd_pkg::FLAG_SF] ^ flags_in[xsd_pkg::FLAG_OF];
  assign set_code = (ins_op1 == xsd_pkg::OP2_SET_BELOW)    ? xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW :
                    (ins_op1 == xsd_pkg::OP2_SET_BELOW_EQ) ?
                      xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL :
                    (ins_op1 == xsd_pkg::OP2_SET_EQUAL)    ? xsd_pkg::XSD_OP_SET_BYTE_IF_EQUAL :
                    (ins_op1 == xsd_pkg::OP2_SET_LESS)     ? xsd_pkg::XSD_OP_SET_BYTE_IF_LESS :
                    (ins_op1 == xsd_pkg::OP2_SET_LESS_EQ)  ?
                      xsd_pkg::XSD_OP_SET_BYTE_IF_LESS_OR_EQUAL :
                    xsd_pkg::XSD_OP_NONE;
  assign set_hold = (set_code == xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW)          ? cf :
                    (set_code == xsd_pkg::XSD_OP_SET_BYTE_IF_BELOW_OR_EQUAL) ? (cf | zf) :
                    (set_code == xsd_pkg::XSD_OP_SET_BYTE_IF_EQUAL)          ? zf :
                    (set_code == xsd_pkg::XSD_OP_SET_BYTE_IF_LESS)           ? lt : (zf | lt);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_sal_cnt;
    take && ins_op0[7:1] == 7'h69 && reg1 == xsd_pkg::REG_SHIFT_LEFT_ARITH |=>
      dec_valid && dec_op == xsd_pkg::XSD_OP_ARITH_SHIFT_LEFT && dec_clocks == 2'h2 &&
      dec_src == xsd_pkg::XSD_SRC_COUNT_REGISTER_LOW && busy ##1 !busy;
  endproperty
  a_sal_cnt: assert property (p_sal_cnt) else $error("shift-left by count bad");

  property p_sal_imm;
    take && ins_op0[7:1] == 7'h60 && reg1 == xsd_pkg::REG_SHIFT_LEFT_ARITH |=>
      dec_valid && dec_op == xsd_pkg::XSD_OP_ARITH_SHIFT_LEFT && dec_imm_byte &&
      dec_clocks == 2'h1 && !busy;
  endproperty
  a_sal_imm: assert property (p_sal_imm) else $error("shift-left by immediate bad");

  property p_sar;
    take && (ins_op0[7:2] == 6'h34 || ins_op0[7:1] == 7'h60) &&
      reg1 == xsd_pkg::REG_SHIFT_RIGHT_ARITH |=>
      dec_valid && dec_op == xsd_pkg::XSD_OP_ARITH_SHIFT_RIGHT && dec_clocks == 2'h2 && busy;
  endproperty
  a_sar: assert property (p_sar) else $error("shift-right bad");

  property p_sbb_rr;
    take && ins_op0[7:2] == xsd_pkg::OP_SBB_RR_TOP && ins_op1[7:6] == xsd_pkg::MOD_REG_DIRECT |=>
      dec_valid && dec_op == xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW && !dec_mem &&
      dec_dir == $past(ins_op0[1]) && dec_width == $past(ins_op0[0]) && dec_clocks == 2'h1;
  endproperty
  a_sbb_rr: assert property (p_sbb_rr) else $error("register borrow subtract bad");

  property p_sbb_mem;
    take && ins_op0[7:2] == xsd_pkg::OP_SBB_RR_TOP && ins_op1[7:6] != 2'h3 && cache_hit |=>
      dec_valid && dec_mem && dec_clocks == 2'h1 && !busy;
  endproperty
  a_sbb_mem: assert property (p_sbb_mem) else $error("memory borrow subtract bad");

  property p_sbb_imm;
    take && ins_op0[7:2] == xsd_pkg::OP_IMM_GROUP_TOP && reg1 == xsd_pkg::REG_SBB_IMM |=>
      dec_valid && dec_op == xsd_pkg::XSD_OP_SUBTRACT_WITH_BORROW &&
      dec_sext == $past(ins_op0[1]) && dec_clocks == 2'h1;
  endproperty
  a_sbb_imm: assert property (p_sbb_imm) else $error("immediate subtract bad");

  property p_set;
    take && ins_op0 == xsd_pkg::OP_TWO_BYTE_ESC && set_code != xsd_pkg::XSD_OP_NONE &&
      ins_modrm2[5:3] == xsd_pkg::REG_SET_BYTE |=>
      set_we && dec_valid && dec_op == $past(set_code) && set_data == {7'h00, $past(set_hold)};
  endproperty
  a_set: assert property (p_set)
    else $error("set-byte result wrong");

  property p_set_flags;
    set_we |-> !flags_we && set_data[7:1] == 7'h00;
  endproperty
  a_set_flags: assert property (p_set_flags) else $error("set-byte touched flags");

  c_set_true: cover property (set_we && set_data == 8'h01);
  c_two_clk: cover property (dec_valid && busy);
  c_mem: cover property (dec_valid && dec_mem);
endmodule : xsd_decode_props

bind xsd_decode xsd_decode_props u_xsd_decode_props
(
  .mclk(mclk), .rst(rst), .ins_valid(ins_valid), .ins_op0(ins_op0), .ins_op1(ins_op1),
  .ins_modrm2(ins_modrm2), .cache_hit(cache_hit), .flags_in(flags_in), .dec_valid(dec_valid),
  .dec_op(dec_op), .dec_src(dec_src), .dec_width(dec_width), .dec_dir(dec_dir),
  .dec_sext(dec_sext), .dec_imm_byte(dec_imm_byte), .dec_mem(dec_mem),
  .dec_clocks(dec_clocks), .set_we(set_we), .set_data(set_data), .flags_we(flags_we),
  .busy(busy)
);

`default_nettype wire
